// [dv/dapr_far_model.sv]
/*
  Far-side model: one DRAM word with its byte parity, and a CPU that
  grants hold one cycle after it is asked.
  Assumes the block's DRAM strobes are registered on pclk.
*/
`default_nettype none
module dapr_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic dram_we_n,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wpar,
  input wire logic hold,
  input wire logic bad_par,
  output logic rd_valid,
  output logic [31:0] rd_data,
  output logic [3:0] rd_par,
  output logic hlda
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [35:0] mem;
  logic cas_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem <= '0;
      cas_q <= 1'b1;
      rd_valid <= 1'b0;
      rd_data <= 32'h0;
      rd_par <= 4'h0;
      hlda <= 1'b0;
    end else begin
      cas_q <= cas_n;
      hlda <= hold;
      rd_valid <= 1'b0;
      // released data lines toggle so a stale word is never mistaken
      rd_data <= ~rd_data;
      rd_par <= ~rd_par;
      if (!ras_n && cas_q && !cas_n && !dram_we_n) begin
        mem <= {wpar, wdata};
      end
      if (!ras_n && cas_q && !cas_n && dram_we_n) begin
        rd_valid <= 1'b1;
        rd_data <= mem[31:0];
        rd_par <= mem[35:32] ^ {3'h0, bad_par};
      end
    end
  end
endmodule
`default_nettype wire

// [dv/dram_addr_mux_parity_refresh_test.sv]
/*
  Self-checking bench of the DRAM address mux, parity and refresh block.
  Assumes the far-side model answers a read one cycle after CAS falls.
*/
`default_nettype none
module dram_addr_mux_parity_refresh_test import dapr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, mux_addr;
  logic [31:0] pwdata, prdata, cpu_wdata, rd_data, rq;
  logic cpu_dram_req, cpu_dram_we, cpu_ready, cpu_wait, rd_valid;
  logic [25:2] cpu_addr;
  logic [3:0] rd_par, wr_par;
  logic cpu_par_err, nmi, ras_n, cas_n, dram_we_n, hold, hlda;
  logic isa_rfsh_n, at_rfsh_n, at_memr_n, bad_par, re;
  logic [7:0] at_addr;
  logic cpu_at_req, cpu_at_gnt, dma_req, dma_gnt;
  logic [11:0] row_v, col_v;
  logic [3:0] wp_v;
  bit pe_seen, w_seen, h_seen;
  int n_errors, check_count, t, aa, seed;
  int gaps[$];
  int ctab[9][5] = '{'{9,10,21,23,25}, '{0,0,0,0,0}, '{0,0,0,0,0},
    '{9,0,0,0,0}, '{9,0,0,0,0}, '{9,0,0,0,0}, '{9,10,0,0,0},
    '{9,10,0,0,0}, '{9,10,21,0,0}};
  int rtab[9][3] = '{'{20,22,24}, '{10,9,0}, '{20,10,9}, '{20,21,10},
    '{10,0,0}, '{20,10,0}, '{20,21,0}, '{20,22,21}, '{20,22,23}};
  int mreg[9] = '{0, 2, 10, 18, 4, 12, 20, 28, 36};
  logic [11:0] radr[5] = '{12'h084, 12'h088, 12'h184, 12'h0C0, 12'h3FC};

  dapr_top #(.SLOW_CYCLES(40)) dapr_top_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_dram_req(cpu_dram_req),
    .cpu_dram_we(cpu_dram_we), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_ready(cpu_ready), .cpu_wait(cpu_wait),
    .cpu_at_req(cpu_at_req), .cpu_at_gnt(cpu_at_gnt), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_par(rd_par), .wr_par(wr_par),
    .cpu_par_err(cpu_par_err), .nmi(nmi), .mux_addr(mux_addr),
    .ras_n(ras_n), .cas_n(cas_n), .dram_we_n(dram_we_n), .hold(hold),
    .hlda(hlda), .dma_req(dma_req), .dma_gnt(dma_gnt),
    .isa_rfsh_n(isa_rfsh_n), .at_rfsh_n(at_rfsh_n), .at_memr_n(at_memr_n),
    .at_addr(at_addr));
  dapr_far_model dapr_far_model_inst (.pclk(pclk), .presetn(presetn),
    .ras_n(ras_n), .cas_n(cas_n), .dram_we_n(dram_we_n),
    .wdata(cpu_wdata), .wpar(wr_par), .hold(hold), .bad_par(bad_par),
    .rd_valid(rd_valid), .rd_data(rd_data), .rd_par(rd_par),
    .hlda(hlda));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic give_up();
    n_errors++;
    print_verdict();
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) give_up();
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cpu_acc(logic we, logic [25:2] a, logic [31:0] d);
    int n;
    bit got;
    got = 0;
    pe_seen = 0;
    w_seen = 0;
    h_seen = 0;
    @(posedge pclk);
    cpu_dram_we <= we;
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_dram_req <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge pclk);
      #1;
      w_seen |= cpu_wait;
      h_seen |= hold;
      pe_seen |= cpu_par_err;
      if (!ras_n && !cas_n && got) begin
        col_v = mux_addr;
        wp_v = wr_par;
      end
      if (!ras_n && cas_n && !got) begin
        row_v = mux_addr;
        got = 1;
      end
      if (cpu_ready === 1'b1) break;
    end
    if (n == 100) give_up();
    @(posedge pclk);
    cpu_dram_req <= 1'b0;
    #1;
    pe_seen |= cpu_par_err;
  endtask
  // counts edges up to the first cycle of a CAS-before-RAS refresh
  task automatic wait_cbr(int lim);
    for (t = 1; t <= lim; t++) begin
      @(posedge pclk);
      #1;
      if (!cas_n && ras_n) break;
    end
    if (t > lim) give_up();
  endtask
  function automatic logic [11:0] exp_ma(int m, bit col, logic [25:0] a);
    logic [11:0] r;
    r = 12'h000;
    for (int i = 0; i < 7; i++) r[i] = col ? a[i + 2] : a[i + 13];
    for (int i = 7; i < 12; i++) begin
      if (col && ctab[m][i - 7] != 0) r[i] = a[ctab[m][i - 7]];
      if (!col && i > 8 && rtab[m][i - 9] != 0) r[i] = a[rtab[m][i - 9]];
    end
    if (!col) r[8:7] = a[12:11];
    return r;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [25:0] a;
    logic [31:0] d;
    logic [3:0] p;
    seed = 32'h8960;
    {presetn, psel, penable, pwrite, cpu_dram_req, cpu_dram_we} = '0;
    {paddr, pwdata, cpu_addr, cpu_wdata, bad_par} = '0;
    {cpu_at_req, dma_req} = '0;
    isa_rfsh_n = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("idle", {ras_n, cas_n, dram_we_n, at_rfsh_n, at_memr_n, hold},
      6'h3E);
    foreach (radr[i]) begin
      apb(1'b0, radr[i], 0);
      chk("reg", rq, 0);
      chk("err", re, i == 4);
    end
    wait_cbr(4000);
    chk("hold", hold, 1'b1);
    for (int m = 0; m < 9; m++) begin
      apb(1'b1, 12'h0C0, mreg[m]);
      apb(1'b0, 12'h0C0, 0);
      chk("mode", rq, mreg[m]);
      a = {24'($random(seed)), 2'h0};
      d = $random(seed);
      for (int i = 0; i < 4; i++) p[i] = ~^d[8 * i +: 8];
      cpu_acc(1'b1, a[25:2], d);
      chk("row", row_v, exp_ma(m, 0, a));
      chk("col", col_v, exp_ma(m, 1, a));
      chk("wpar", wp_v, p);
      cpu_acc(1'b0, a[25:2], d);
      chk("perr", pe_seen, 1'b0);
    end
    bad_par <= 1'b1;
    cpu_acc(1'b0, a[25:2], d);
    bad_par <= 1'b0;
    chk("perr", pe_seen, 1'b1);
    apb(1'b0, 12'h0C4, 0);
    chk("stat", rq[BIT_STAT_PERR], 1'b1);
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, 12'h084, k[0] << 5);
      apb(1'b1, 12'h184, k[2:1] << 2);
      @(posedge pclk);
      #1;
      chk("nmi", nmi, k == 7);
    end
    apb(1'b1, 12'h0C4, 1);
    @(posedge pclk);
    #1;
    chk("nmi", nmi, 1'b0);
    apb(1'b1, 12'h0C0, 1);
    wait_cbr(4000);
    chk("at", {at_rfsh_n, at_memr_n}, 2'h0);
    aa = at_addr;
    @(posedge pclk);
    #1;
    chk("cbr", {ras_n, cas_n}, 2'h0);
    wait_cbr(4000);
    // one edge went to the refresh shape check before counting resumed
    gaps.push_back(t + 1);
    chk("gap", gaps[0], RFSH_CYC);
    chk("hold", hold, 1'b0);
    chk("atad", at_addr, (aa + 1) % 256);
    repeat (20) @(posedge pclk);
    // stands in for a long-owning ISA master refreshing by itself
    isa_rfsh_n <= 1'b0;
    wait_cbr(50);
    chk("atside", at_rfsh_n, 1'b1);
    @(posedge pclk);
    isa_rfsh_n <= 1'b1;
    cpu_acc(1'b1, a[25:2], d);
    chk("wait", {w_seen, h_seen}, 2'h2);
    apb(1'b1, 12'h088, 1);
    wait_cbr(4000);
    wait_cbr(100);
    wait_cbr(100);
    chk("slow", t, 40);
    // at side: cpu stalls behind refresh, then dma beats the cpu
    wait_cbr(100);
    @(posedge pclk);
    cpu_at_req <= 1'b1;
    dma_req <= 1'b1;
    @(posedge pclk);
    #1;
    chk("atwait", cpu_wait, 1'b1);
    repeat (6) @(posedge pclk);
    #1;
    chk("dmagnt", {dma_gnt, cpu_at_gnt}, 2'h2);
    @(posedge pclk);
    dma_req <= 1'b0;
    repeat (5) @(posedge pclk);
    #1;
    chk("atgnt", {dma_gnt, cpu_at_gnt}, 2'h1);
    @(posedge pclk);
    cpu_at_req <= 1'b0;
    print_verdict();
  end
endmodule
`default_nettype wire

// [inc/dapr_pkg.sv]
/*
  Shared constants, register layout and carrier types of the DRAM
  address mux, parity and refresh block.
  Assumes a single 200 MHz clock and a 32-bit APB register port.
*/
`default_nettype none
package dapr_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CFG21 = 8'h21;
  localparam logic [7:0] IDX_CFG22 = 8'h22;
  localparam logic [7:0] IDX_PORTB = 8'h61;
  localparam logic [7:0] IDX_MODE = 8'h30;
  localparam logic [7:0] IDX_STAT = 8'h31;
  localparam int BIT_PAR_EN = 5;
  localparam int BIT_SLOW = 0;
  localparam int BIT_PB_LO = 2;
  localparam int BIT_PB_HI = 3;
  localparam int BIT_HIDDEN = 0;
  localparam int BIT_STAT_PERR = 0;
  localparam int BIT_STAT_DPEND = 1;
  localparam int BIT_STAT_APEND = 2;
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic PAR_ODD = 1'b1;
  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RFSH_PERIOD_PS = 15900000;
  localparam int RFSH_CYC = RFSH_PERIOD_PS / CLK_PERIOD_PS;
  localparam int SLOW_DIV = 4;
  localparam int SLOW_CYC = RFSH_CYC * SLOW_DIV;
  localparam logic [3:0] T_RCD = 4'h2;
  localparam logic [3:0] T_CAS = 4'h2;
  localparam logic [3:0] T_RP = 4'h2;
  localparam logic [3:0] T_CSR = 4'h1;
  localparam logic [3:0] T_RAS = 4'h4;
  localparam logic [3:0] T_AT_RFSH = 4'h6;

  typedef enum logic [1:0] {
    DT_STD = 2'h0,
    DT_12X8 = 2'h1,
    DT_11X9 = 2'h2
  } dapr_dtype_t;
  typedef enum logic [2:0] {
    SZ_256K = 3'h0,
    SZ_512K = 3'h1,
    SZ_1M = 3'h2,
    SZ_2M = 3'h3,
    SZ_4M = 3'h4
  } dapr_dsize_t;
  typedef struct packed {
    logic hidden;
    logic slow;
    logic par_en;
    logic [1:0] portb_par;
    dapr_dtype_t dtype;
    dapr_dsize_t dsize;
  } dapr_cfg_t;

  function automatic logic dapr_bpar(input logic [7:0] b);
    return (^b) ^ PAR_ODD;
  endfunction
endpackage
`default_nettype wire

// [rtl/dapr_addr_mux.sv]
/*
  Row and column multiplexer from CPU address to the DRAM address bus.
  Assumes the caller registers the result before it reaches the pins.
*/
`default_nettype none
module dapr_addr_mux import dapr_pkg::*; (
  input wire logic [25:2] cpu_a,
  input wire logic col,
  input wire dapr_dtype_t dtype,
  input wire dapr_dsize_t dsize,
  output logic [11:0] mux_addr
);
  logic [25:0] a;
  logic big;
  assign a = {cpu_a, 2'h0};
  assign big = (dsize == SZ_1M) || (dsize == SZ_2M) || (dsize == SZ_4M);

  always_comb begin
    if (col) begin
      mux_addr = {5'h00, a[8:2]};
      if (dtype == DT_STD) begin
        mux_addr = {a[25], a[23], a[21], a[10:2]};
      end else if (dtype == DT_12X8) begin
        if (big) begin
          mux_addr[7] = a[9];
        end
      end else begin
        mux_addr[7] = a[9];
        mux_addr[8] = big ? a[10] : 1'b0;
        mux_addr[9] = (dsize == SZ_4M) ? a[21] : 1'b0;
      end
    end else begin
      mux_addr = {3'h0, a[12], a[11], a[19:13]};
      if (dtype == DT_STD) begin
        mux_addr = {a[24], a[22], a[20], a[12], a[11], a[19:13]};
      end else if (dtype == DT_12X8) begin
        case (dsize)
          SZ_256K: mux_addr[11:9] = {1'b0, a[9], a[10]};
          SZ_512K: mux_addr[11:9] = {a[9], a[10], a[20]};
          default: mux_addr[11:9] = {a[10], a[21], a[20]};
        endcase
      end else begin
        case (dsize)
          SZ_256K: mux_addr[11:9] = {2'h0, a[10]};
          SZ_512K: mux_addr[11:9] = {1'b0, a[10], a[20]};
          SZ_1M: mux_addr[11:9] = {1'b0, a[21], a[20]};
          SZ_2M: mux_addr[11:9] = {a[21], a[22], a[20]};
          default: mux_addr[11:9] = {a[23], a[22], a[20]};
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/dapr_parity.sv]
/*
  Per-byte parity generation for writes and checking for reads.
  Assumes 32-bit data with one parity bit per byte lane.
*/
`default_nettype none
module dapr_parity import dapr_pkg::*; (
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic [3:0] rpar,
  output logic [3:0] wpar,
  output logic mismatch
);
  logic [3:0] rgen;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wpar[i] = dapr_bpar(wdata[8*i +: 8]);
      rgen[i] = dapr_bpar(rdata[8*i +: 8]);
    end
  end
  assign mismatch = |(rgen ^ rpar);
endmodule
`default_nettype wire

// [rtl/dapr_top.sv]
/*
  DRAM address multiplexing, byte parity and refresh scheduling,
  with an APB register port.
  Assumes CPU and DRAM data-path signals are on pclk; hold acknowledge,
  DMA request and ISA master refresh arrive asynchronously from pins.
*/
// Register access over APB and the register addresses were decided locally.
`default_nettype none
// Behaviour
// - standard DRAM column: bits 0-8 A2-A10, bits 9-11 A21,A23,A25
// - standard DRAM row: A13-A19, A11, A12, A20, A22, A24
// - asymmetric parts: low seven bits A2-A8 column, A13-A19 row
// - 12x8 parts: high row and column bits chosen per size
// - 11x9 column: A9 always, A10 from 1M, A21 only at 4M
// - 11x9 row bits 9-11 chosen per size
// - each written byte gets a parity bit stored with it
// - each read byte is checked; mismatch flags a parity error
// - parity error raises NMI only with config 21h bit 5 set
// - NMI also requires system port 61h bits 2 and 3
// - reset selects normal refresh: CPU held during combined refresh
// - hidden refresh never holds CPU; waits stall CPU on busy resource
// - hidden refresh runs AT and DRAM refresh independently
// - DRAM side and AT side each arbitrate their own requesters
// - AT refresh drives refresh strobe, memory read and row address
// - local DRAM refresh is always CAS-before-RAS
// - rate counter issues refresh request every 15.9 us
// - refresh requested by timer or by a 16-bit ISA master
// - config 22h bit 0 divides refresh rate by four
module dapr_top import dapr_pkg::*; #(
  parameter int SLOW_CYCLES = SLOW_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_dram_req,
  input wire logic cpu_dram_we,
  input wire logic [25:2] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  output logic cpu_ready,
  output logic cpu_wait,
  input wire logic cpu_at_req,
  output logic cpu_at_gnt,
  input wire logic rd_valid,
  input wire logic [31:0] rd_data,
  input wire logic [3:0] rd_par,
  output logic [3:0] wr_par,
  output logic cpu_par_err,
  output logic nmi,
  output logic [11:0] mux_addr,
  output logic ras_n,
  output logic cas_n,
  output logic dram_we_n,
  output logic hold,
  input wire logic hlda,
  input wire logic dma_req,
  output logic dma_gnt,
  input wire logic isa_rfsh_n,
  output logic at_rfsh_n,
  output logic at_memr_n,
  output logic [7:0] at_addr
);
  typedef enum logic [5:0] {
    D_IDLE = 6'h01, D_RAS = 6'h02, D_CAS = 6'h04,
    D_PRE = 6'h08, D_CBR_CAS = 6'h10, D_CBR_RAS = 6'h20
  } dapr_dst_t;
  typedef enum logic [3:0] {
    A_IDLE = 4'h1, A_RFSH = 4'h2, A_DMA = 4'h4, A_CPU = 4'h8
  } dapr_ast_t;

  dapr_cfg_t cfg;
  logic perr;
  dapr_dst_t dst;
  dapr_ast_t ast;
  logic [3:0] dcnt, acnt;
  logic dram_pend, at_pend, dram_done, at_done;
  logic [15:0] rate_cnt;
  logic refresh_timer_output;
  logic hlda_m, hlda_s, dma_m, dma_s, isa_m, isa_s, isa_d;
  logic [11:0] row_mux, col_mux;
  logic [3:0] gen_par;
  logic rd_bad;
  logic [7:0] idx;
  logic acc, wr_go, mapped;

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {hlda_m, hlda_s, dma_m, dma_s} <= 4'h0;
      {isa_m, isa_s, isa_d} <= 3'h7;
    end else begin
      hlda_m <= hlda;
      hlda_s <= hlda_m;
      dma_m <= dma_req;
      dma_s <= dma_m;
      isa_m <= isa_rfsh_n;
      isa_s <= isa_m;
      isa_d <= isa_s;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, unmapped indices answer with an error
  assign idx = paddr[9:2];
  assign acc = psel && penable && !pready;
  assign wr_go = psel && penable && pready && pwrite;
  assign mapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
    (idx == IDX_CFG21 || idx == IDX_CFG22 || idx == IDX_PORTB ||
     idx == IDX_MODE || idx == IDX_STAT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc;
      pslverr <= acc && !mapped;
      prdata <= 32'h0000_0000;
      if (acc && !pwrite) begin
        if (idx == IDX_CFG21) begin
          prdata[BIT_PAR_EN] <= cfg.par_en;
        end else if (idx == IDX_CFG22) begin
          prdata[BIT_SLOW] <= cfg.slow;
        end else if (idx == IDX_PORTB) begin
          prdata[BIT_PB_HI:BIT_PB_LO] <= cfg.portb_par;
        end else if (idx == IDX_MODE) begin
          prdata[5:0] <= {cfg.dsize, cfg.dtype, cfg.hidden};
        end else if (idx == IDX_STAT) begin
          prdata[BIT_STAT_PERR] <= perr;
          prdata[BIT_STAT_DPEND] <= dram_pend;
          prdata[BIT_STAT_APEND] <= at_pend;
          prdata[15:8] <= at_addr;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= '0;
    end else if (wr_go && mapped) begin
      if (idx == IDX_CFG21) begin
        cfg.par_en <= pwdata[BIT_PAR_EN];
      end else if (idx == IDX_CFG22) begin
        cfg.slow <= pwdata[BIT_SLOW];
      end else if (idx == IDX_PORTB) begin
        cfg.portb_par <= pwdata[BIT_PB_HI:BIT_PB_LO];
      end else if (idx == IDX_MODE) begin
        cfg.hidden <= pwdata[BIT_HIDDEN];
        cfg.dtype <= dapr_dtype_t'(pwdata[2:1]);
        cfg.dsize <= dapr_dsize_t'(pwdata[5:3]);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // parity
  dapr_parity u_par (
    .wdata(cpu_wdata),
    .rdata(rd_data),
    .rpar(rd_par),
    .wpar(gen_par),
    .mismatch(rd_bad)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_par <= 4'h0;
      cpu_par_err <= 1'b0;
      perr <= 1'b0;
      nmi <= 1'b0;
    end else begin
      if (dst == D_IDLE && cpu_dram_req && cpu_dram_we) begin
        wr_par <= gen_par;
      end
      cpu_par_err <= rd_valid && rd_bad;
      // a new error wins over a write-one clear in the same cycle
      if (rd_valid && rd_bad) begin
        perr <= 1'b1;
      end else if (wr_go && mapped && idx == IDX_STAT &&
          pwdata[BIT_STAT_PERR]) begin
        perr <= 1'b0;
      end
      nmi <= perr && cfg.par_en && (&cfg.portb_par);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // refresh rate counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_cnt <= 16'h0000;
      refresh_timer_output <= 1'b0;
    end else begin
      refresh_timer_output <= (rate_cnt == 16'h0000);
      if (rate_cnt == 16'h0000) begin
        rate_cnt <= cfg.slow ? 16'(SLOW_CYCLES - 1)
                             : 16'(RFSH_CYC - 1);
      end else begin
        rate_cnt <= rate_cnt - 16'h0001;
      end
    end
  end

  // pending requests; a new request wins over a completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dram_pend <= 1'b0;
      at_pend <= 1'b0;
    end else begin
      if (refresh_timer_output || (isa_d && !isa_s)) begin
        dram_pend <= 1'b1;
      end else if (dram_done) begin
        dram_pend <= 1'b0;
      end
      if (refresh_timer_output) begin
        at_pend <= 1'b1;
      end else if (at_done) begin
        at_pend <= 1'b0;
      end
    end
  end

  // normal mode holds the cpu for the combined refresh
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold <= 1'b0;
    end else begin
      hold <= !cfg.hidden && (dram_pend || at_pend);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // dram side: cpu access against cbr refresh
  dapr_addr_mux u_row (
    .cpu_a(cpu_addr), .col(1'b0), .dtype(cfg.dtype),
    .dsize(cfg.dsize), .mux_addr(row_mux)
  );
  dapr_addr_mux u_col (
    .cpu_a(cpu_addr), .col(1'b1), .dtype(cfg.dtype),
    .dsize(cfg.dsize), .mux_addr(col_mux)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dst <= D_IDLE;
      dcnt <= 4'h0;
      ras_n <= 1'b1;
      cas_n <= 1'b1;
      dram_we_n <= 1'b1;
      mux_addr <= 12'h000;
      cpu_ready <= 1'b0;
      dram_done <= 1'b0;
    end else begin
      cpu_ready <= 1'b0;
      dram_done <= 1'b0;
      dcnt <= dcnt - 4'h1;
      case (dst)
        D_IDLE: begin
          if (dram_pend && !dram_done &&
              (cfg.hidden || (hold && hlda_s))) begin
            dst <= D_CBR_CAS;
            cas_n <= 1'b0;
            dcnt <= T_CSR;
          end else if (cpu_dram_req && !hold) begin
            dst <= D_RAS;
            mux_addr <= row_mux;
            ras_n <= 1'b0;
            dcnt <= T_RCD;
          end
        end
        D_RAS: begin
          if (dcnt == 4'h1) begin
            dst <= D_CAS;
            mux_addr <= col_mux;
            cas_n <= 1'b0;
            dram_we_n <= !cpu_dram_we;
            dcnt <= T_CAS;
          end
        end
        D_CAS: begin
          if (dcnt == 4'h1) begin
            dst <= D_PRE;
            ras_n <= 1'b1;
            cas_n <= 1'b1;
            dram_we_n <= 1'b1;
            cpu_ready <= 1'b1;
            dcnt <= T_RP;
          end
        end
        D_CBR_CAS: begin
          if (dcnt == 4'h1) begin
            dst <= D_CBR_RAS;
            ras_n <= 1'b0;
            dcnt <= T_RAS;
          end
        end
        D_CBR_RAS: begin
          if (dcnt == 4'h1) begin
            dst <= D_PRE;
            ras_n <= 1'b1;
            cas_n <= 1'b1;
            dram_done <= 1'b1;
            dcnt <= T_RP;
          end
        end
        D_PRE: begin
          if (dcnt == 4'h1) begin
            dst <= D_IDLE;
          end
        end
        default: dst <= D_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // at side: cpu, dma and at refresh, refresh first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ast <= A_IDLE;
      acnt <= 4'h0;
      at_rfsh_n <= 1'b1;
      at_memr_n <= 1'b1;
      at_addr <= 8'h00;
      at_done <= 1'b0;
      dma_gnt <= 1'b0;
      cpu_at_gnt <= 1'b0;
    end else begin
      at_done <= 1'b0;
      acnt <= acnt - 4'h1;
      case (ast)
        A_IDLE: begin
          if (at_pend && !at_done && (cfg.hidden || (hold && hlda_s))) begin
            ast <= A_RFSH;
            at_rfsh_n <= 1'b0;
            at_memr_n <= 1'b0;
            acnt <= T_AT_RFSH;
          end else if (dma_s) begin
            ast <= A_DMA;
            dma_gnt <= 1'b1;
          end else if (cpu_at_req && !hold) begin
            ast <= A_CPU;
            cpu_at_gnt <= 1'b1;
          end
        end
        A_RFSH: begin
          if (acnt == 4'h1) begin
            ast <= A_IDLE;
            at_rfsh_n <= 1'b1;
            at_memr_n <= 1'b1;
            at_addr <= at_addr + 8'h01;
            at_done <= 1'b1;
          end
        end
        A_DMA: begin
          if (!dma_s) begin
            ast <= A_IDLE;
            dma_gnt <= 1'b0;
          end
        end
        A_CPU: begin
          if (!cpu_at_req) begin
            ast <= A_IDLE;
            cpu_at_gnt <= 1'b0;
          end
        end
        default: ast <= A_IDLE;
      endcase
    end
  end

  // hidden mode stalls the cpu only on the resource being refreshed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_wait <= 1'b0;
    end else begin
      cpu_wait <= (cpu_dram_req && (dst == D_CBR_CAS ||
                   dst == D_CBR_RAS)) ||
                  (cpu_at_req && ast == A_RFSH);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  a_cbr_order: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(ras_n) && dst == D_CBR_RAS |-> $past(!cas_n, 1))
    else $error("refresh ras fell without cas low");
  a_nmi_enable: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(nmi) |-> $past(cfg.par_en && perr, 1))
    else $error("nmi rose without parity enable");
  a_nmi_portb: assert property (@(posedge pclk) disable iff (!presetn)
    nmi |-> $past(cfg.portb_par, 1) == 2'h3)
    else $error("nmi without port enables");
  a_normal_hold: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(at_rfsh_n) && !cfg.hidden |-> hold && hlda_s)
    else $error("normal refresh started without hold");
  a_hidden_free: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.hidden && $past(cfg.hidden, 1) |-> !hold)
    else $error("hidden mode held the cpu");
  a_at_rfsh_cmd: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(at_rfsh_n) |-> !at_memr_n ##6 at_rfsh_n && at_memr_n)
    else $error("at refresh command shape wrong");
  a_pend_kept: assert property (@(posedge pclk) disable iff (!presetn)
    dram_pend && !dram_done |=> dram_pend)
    else $error("refresh request lost");
  a_par_flag: assert property (@(posedge pclk) disable iff (!presetn)
    rd_valid && rd_bad |=> cpu_par_err ##1 perr)
    else $error("parity mismatch not flagged");
  a_timer_gap: assert property (@(posedge pclk) disable iff (!presetn)
    refresh_timer_output && !cfg.slow |=>
      !refresh_timer_output [*8])
    else $error("refresh ticks too close");
endmodule
`default_nettype wire
